// file: plc_editor_pkg.sv
// Function
// R1 - step field shows step, timer/counter values, data registers without leading zeros
// R2 - device field: inputs/outputs hex with zeros kept, others decimal without zeros
// R3 - insert moves words from chosen step one later, new word at step
// R4 - delete moves words from step plus one one earlier, dropping chosen word
// R5 - monitor reports device on/off, timer/counter values and data registers
// R6 - test forces outputs, sets/resets relays, clears values, reads error step; the unit never issues the clear-value request
// R7 - clear erases entry and display, leaves program, returns to ready
// R8 - power keys switch only the unit's control section, never the cpu
// R9 - forward key advances/inserts/forces on; back key retreats/deletes/forces off
// R10 - write, insert, delete refused while cpu runs unless run-write allowed
// R11 - jump target below current step or above cpu maximum is an error
// R12 - insertion pushing jump target past maximum shows error but still inserts
// R13 - coil used elsewhere raises duplicate warning, word still written
// R14 - undecodable stored code shows instruction-code error instead
// R15 - bad instruction/device pairing or missing extra words is entry error
// R16 - unassignable device number error; over-largest device number separate error
// R17 - any key but clear before mode selection is mode-selection error; the power-off key is also exempt
// R18 - undefined key sequence is operation error, restart from initial-step key
// R19 - ready message after control power on and after clear
// R20 - step number above installed memory maximum is step-overflow error
// R21 - every write is read back and compared, mismatch is write error; shift writes of insert/delete are not read back
// R22 - search miss shows not-found notice, not an error, next operation allowed
package plc_editor_pkg;
	localparam int ADDR_W = 12;
	localparam int WORD_W = 16;
	localparam int DEV_W = 12;
	localparam logic [ADDR_W-1:0] MAX_STEP_1K = 12'h03_FF;
	localparam logic [ADDR_W-1:0] MAX_STEP_2K = 12'h07_FF;
	localparam logic [ADDR_W-1:0] MAX_STEP_4K = 12'h0F_FF;
	localparam logic [WORD_W-1:0] WORD_NOP = 16'h0000;
	localparam logic [3:0] OP_JUMP = 4'h9;
	localparam logic [3:0] OP_OUT = 4'h3;
	localparam logic [3:0] OP_MULTI = 4'hA;
	localparam logic [3:0] OP_BAD = 4'hF;
	localparam int DIGITS = 4;

	typedef enum logic [3:0] {
		KEY_NONE = 4'h0, KEY_READ = 4'h1, KEY_WRITE = 4'h2, KEY_INSDEL = 4'h3,
		KEY_MONITOR = 4'h4, KEY_TEST = 4'h5, KEY_CLEAR = 4'h6, KEY_SET_STEP = 4'h7,
		KEY_FWD = 4'h8, KEY_BACK = 4'h9, KEY_INSTR = 4'hA, KEY_SEARCH = 4'hB,
		KEY_PWR_ON = 4'hC, KEY_PWR_OFF = 4'hD, KEY_DEVICE = 4'hE, KEY_BAD = 4'hF
	} key_type;

	typedef enum logic [2:0] {
		MODE_NONE = 3'b000, MODE_READ = 3'b001, MODE_WRITE = 3'b010,
		MODE_INSDEL = 3'b011, MODE_MONITOR = 3'b100, MODE_TEST = 3'b101
	} mode_type;

	typedef enum logic [3:0] {
		MSG_NONE = 4'h0, MSG_NOT_FOUND = 4'h1, MSG_OP_BLOCKED = 4'h2,
		MSG_JUMP_TARGET = 4'h3, MSG_DUAL_COIL = 4'h4, MSG_CODE = 4'h5,
		MSG_ENTRY = 4'h6, MSG_DEV_SET = 4'h7, MSG_DEV_OVER = 4'h8,
		MSG_MODE_SEL = 4'h9, MSG_UNDEF_OP = 4'hA, MSG_READY = 4'hB,
		MSG_STEP_OVER = 4'hC, MSG_WRITE_ERR = 4'hD
	} msg_type;

	typedef enum logic [3:0] {
		DEV_IN = 4'h0, DEV_OUT = 4'h1, DEV_AUX = 4'h2, DEV_TIMER = 4'h3,
		DEV_COUNT = 4'h4, DEV_FLAG = 4'h5, DEV_CONST = 4'h6, DEV_DATA = 4'h7
	} dev_kind_type;

	typedef struct packed {
		key_type key;
		logic [WORD_W-1:0] value;
	} key_evt_type;

	typedef struct packed {
		logic req;
		logic wr;
		logic [ADDR_W-1:0] addr;
		logic [WORD_W-1:0] data;
	} mem_req_type;

	typedef struct packed {
		logic req;
		logic [1:0] op;
		dev_kind_type kind;
		logic [DEV_W-1:0] num;
	} dev_req_type;

	typedef struct packed {
		logic [DIGITS*4-1:0] step_digits;
		logic [3:0] step_blank;
		logic [WORD_W-1:0] instr;
		logic state_on;
		logic [DIGITS*4-1:0] dev_digits;
		logic [3:0] dev_blank;
		msg_type msg;
	} display_type;

	localparam logic [1:0] DOP_READ = 2'b00;
	localparam logic [1:0] DOP_FORCE_ON = 2'b01;
	localparam logic [1:0] DOP_FORCE_OFF = 2'b10;
	localparam logic [1:0] DOP_CLEAR_VAL = 2'b11;
endpackage : plc_editor_pkg

// file: plc_mem_model.sv
`timescale 1ns/1ns
module plc_mem_model (
	input wire logic clk_in,
	input wire plc_editor_pkg::mem_req_type mem_req_in,
	output logic mem_ack_out,
	output logic [plc_editor_pkg::WORD_W-1:0] mem_rdata_out,
	input wire plc_editor_pkg::dev_req_type dev_req_in,
	output logic dev_ack_out,
	output logic dev_state_out,
	output logic [plc_editor_pkg::WORD_W-1:0] dev_value_out,
	input wire logic [3:0] delay_in,
	input wire logic corrupt_in
);
	import plc_editor_pkg::*;
	logic [WORD_W-1:0] mem [0:4095];
	logic dev_st [0:4095];
	logic [WORD_W-1:0] dev_val [0:4095];
	int wait_cnt;
	initial begin
		for (int i = 0; i < 4096; i++) begin
			mem[i] = WORD_NOP;
			dev_st[i] = 1'b0;
			dev_val[i] = 16'h0000;
		end
		{mem_ack_out, dev_ack_out, dev_state_out} = 3'b000;
		mem_rdata_out = 16'h0000;
		dev_value_out = 16'h0000;
		wait_cnt = 0;
	end
	// answers stand one cycle; stale data toggles so it never passes for valid
	always @(negedge clk_in) begin
		mem_ack_out <= 1'b0;
		dev_ack_out <= 1'b0;
		mem_rdata_out <= ~mem_rdata_out;
		dev_value_out <= ~dev_value_out;
		if ((mem_req_in.req || dev_req_in.req) && !mem_ack_out && !dev_ack_out) begin
			if (wait_cnt < delay_in) begin
				wait_cnt <= wait_cnt + 1;
			end else if (mem_req_in.req) begin
				wait_cnt <= 0;
				mem_ack_out <= 1'b1;
				if (mem_req_in.wr) begin
					mem[mem_req_in.addr] <= corrupt_in ? ~mem_req_in.data : mem_req_in.data;
				end else begin
					mem_rdata_out <= mem[mem_req_in.addr];
				end
			end else begin
				wait_cnt <= 0;
				dev_ack_out <= 1'b1;
				dev_state_out <= (dev_req_in.op == DOP_FORCE_ON) ||
					(dev_req_in.op == DOP_READ && dev_st[dev_req_in.num]);
				dev_value_out <= (dev_req_in.op == DOP_CLEAR_VAL) ? 16'h0000 : dev_val[dev_req_in.num];
				if (dev_req_in.op == DOP_FORCE_ON || dev_req_in.op == DOP_FORCE_OFF) begin
					dev_st[dev_req_in.num] <= (dev_req_in.op == DOP_FORCE_ON);
				end
			end
		end
	end
endmodule : plc_mem_model

// file: plc_program_editor_unit.sv
`timescale 1ns/1ns
module plc_program_editor_unit #(
	parameter int DEV_MAX = 255
) (
	input wire logic clk_in,
	input wire logic srst_in,
	input wire logic key_valid_in,
	input wire plc_editor_pkg::key_evt_type key_in,
	input wire logic [1:0] cpu_size_sel_in,
	input wire logic [plc_editor_pkg::ADDR_W-1:0] mem_max_step_in,
	input wire logic cpu_running_in,
	input wire logic run_write_enable_in,
	input wire logic [plc_editor_pkg::ADDR_W-1:0] program_end_in,
	input wire logic [plc_editor_pkg::ADDR_W-1:0] code_error_step_in,
	output plc_editor_pkg::mem_req_type mem_req_out,
	input wire logic mem_ack_in,
	input wire logic [plc_editor_pkg::WORD_W-1:0] mem_rdata_in,
	output plc_editor_pkg::dev_req_type dev_req_out,
	input wire logic dev_ack_in,
	input wire logic dev_state_in,
	input wire logic [plc_editor_pkg::WORD_W-1:0] dev_value_in,
	input wire logic coil_used_in,
	output logic unit_power_out,
	output logic busy_out,
	output plc_editor_pkg::display_type display_out
);
	import plc_editor_pkg::*;

	typedef enum logic [3:0] {
		ST_OFF = 4'h0, ST_IDLE = 4'h1, ST_RD = 4'h2, ST_WR = 4'h3, ST_VERIFY = 4'h4,
		ST_SH_RD = 4'h5, ST_SH_WR = 4'h6, ST_DEV = 4'h7, ST_SEARCH = 4'h8
	} state_type;

	state_type state_r;
	mode_type mode_r;
	msg_type msg_r;
	logic [ADDR_W-1:0] step_r, ptr_r;
	logic [WORD_W-1:0] entry_r, word_r, show_r;
	logic entry_ok_r, insert_r, on_r, show_dev_r;
	dev_kind_type kind_r;
	logic [DEV_W-1:0] dev_r;
	mem_req_type mem_r;
	dev_req_type devq_r;

	function automatic logic [DIGITS*4-1:0] to_bcd(input logic [WORD_W-1:0] v);
		logic [DIGITS*4-1:0] b;
		b = '0;
		for (int i = WORD_W-1; i >= 0; i--) begin
			for (int d = 0; d < DIGITS; d++) begin
				if (b[d*4 +: 4] > 4'd4) begin
					b[d*4 +: 4] = b[d*4 +: 4] + 4'd3;
				end
			end
			b = {b[DIGITS*4-2:0], v[i]};
		end
		return b;
	endfunction : to_bcd

	function automatic logic [3:0] blanks(input logic [DIGITS*4-1:0] d);
		logic [3:0] m;
		logic lead;
		m = '0;
		lead = 1'b1;
		for (int k = DIGITS-1; k > 0; k--) begin
			lead = lead & (d[k*4 +: 4] == 4'h0);
			m[k] = lead;
		end
		return m;
	endfunction : blanks

	wire [3:0] entry_op = entry_r[15:12];
	wire [ADDR_W-1:0] entry_arg = entry_r[ADDR_W-1:0];
	wire [ADDR_W-1:0] cpu_max = (cpu_size_sel_in == 2'd0) ? MAX_STEP_1K :
		(cpu_size_sel_in == 2'd1) ? MAX_STEP_2K : MAX_STEP_4K;
	wire mode_key = key_in.key inside {KEY_READ, KEY_WRITE, KEY_INSDEL, KEY_MONITOR, KEY_TEST};
	wire edit_mode = mode_r == MODE_WRITE || mode_r == MODE_INSDEL;
	wire blocked = cpu_running_in && !run_write_enable_in; // R10
	wire jump_low = entry_op == OP_JUMP && entry_arg < step_r; // R11
	wire jump_high = entry_op == OP_JUMP && entry_arg > cpu_max; // R11
	wire [ADDR_W:0] end_plus = {1'b0, program_end_in} + {{ADDR_W{1'b0}}, 1'b1};
	wire push_over = insert_r && end_plus > {1'b0, cpu_max}; // R12
	wire entry_bad = entry_op == OP_BAD || (entry_op == OP_MULTI && !entry_ok_r); // R15
	wire [DEV_W-1:0] key_dev = key_in.value[DEV_W-1:0];
	wire dev_over = key_dev > DEV_W'(DEV_MAX); // R16
	wire dev_unset = key_in.value[15:12] > 4'h7; // R16
	wire step_over = key_in.value[ADDR_W-1:0] > mem_max_step_in; // R20
	wire hex_dev = kind_r == DEV_IN || kind_r == DEV_OUT;
	wire [DIGITS*4-1:0] dev_bcd = to_bcd({4'h0, dev_r});
	wire [DIGITS*4-1:0] step_bcd = to_bcd(show_dev_r ? show_r : {4'h0, step_r});
	wire key_go = key_valid_in && state_r == ST_IDLE;

	assign display_out = '{step_bcd, blanks(step_bcd), word_r, on_r, // R1
		hex_dev ? {4'h0, dev_r} : dev_bcd, hex_dev ? 4'h0 : blanks(dev_bcd), msg_r}; // R2

	assign mem_req_out = mem_r;
	assign dev_req_out = devq_r;
	assign unit_power_out = state_r != ST_OFF; // R8
	assign busy_out = state_r != ST_IDLE && state_r != ST_OFF;

	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			state_r <= ST_OFF;
			mode_r <= MODE_NONE;
			msg_r <= MSG_NONE;
			step_r <= '0;
			ptr_r <= '0;
			entry_r <= '0;
			word_r <= '0;
			show_r <= '0;
			entry_ok_r <= 1'b0;
			insert_r <= 1'b0;
			on_r <= 1'b0;
			show_dev_r <= 1'b0;
			kind_r <= DEV_IN;
			dev_r <= '0;
			mem_r <= '0;
			devq_r <= '0;
		end else begin
			case (state_r)
				ST_OFF: begin
					if (key_valid_in && key_in.key == KEY_PWR_ON) begin // R8
						state_r <= ST_IDLE;
						msg_r <= MSG_READY; // R19
						mode_r <= MODE_NONE;
					end
				end
				ST_IDLE: begin
					if (key_go) begin
						if (key_in.key == KEY_PWR_OFF) begin
							state_r <= ST_OFF; // R8
						end else if (key_in.key == KEY_CLEAR) begin
							entry_r <= '0; // R7
							word_r <= '0;
							show_dev_r <= 1'b0;
							on_r <= 1'b0;
							msg_r <= MSG_READY; // R19
						end else if (mode_key) begin
							mode_r <= mode_type'(key_in.key[2:0] - 3'd0);
							msg_r <= MSG_NONE;
						end else if (mode_r == MODE_NONE) begin
							msg_r <= MSG_MODE_SEL; // R17
						end else begin
							case (key_in.key)
								KEY_SET_STEP: begin
									if (step_over) begin
										msg_r <= MSG_STEP_OVER; // R20
									end else if (mode_r == MODE_TEST && key_in.value[15]) begin
										show_r <= {4'h0, code_error_step_in}; // R6
										show_dev_r <= 1'b1;
									end else begin
										step_r <= key_in.value[ADDR_W-1:0];
										msg_r <= MSG_NONE;
									end
								end
								KEY_INSTR: begin
									if (!edit_mode) begin
										msg_r <= MSG_UNDEF_OP; // R18
									end else begin
										entry_r <= key_in.value;
										entry_ok_r <= key_in.value[11] || key_in.value[15:12] != OP_MULTI;
									end
								end
								KEY_DEVICE: begin
									if (dev_unset) begin
										msg_r <= MSG_DEV_SET; // R16
									end else if (dev_over) begin
										msg_r <= MSG_DEV_OVER; // R16
									end else begin
										kind_r <= dev_kind_type'(key_in.value[15:12]);
										dev_r <= key_dev;
										if (mode_r == MODE_MONITOR || mode_r == MODE_TEST) begin
											devq_r <= '{1'b1, DOP_READ, dev_kind_type'(key_in.value[15:12]), key_dev};
											state_r <= ST_DEV;
										end
									end
								end
								KEY_SEARCH: begin
									if (mode_r == MODE_READ) begin
										entry_r <= key_in.value;
										mem_r <= '{1'b1, 1'b0, step_r, '0};
										state_r <= ST_SEARCH;
									end else begin
										msg_r <= MSG_UNDEF_OP; // R18
									end
								end
								KEY_FWD, KEY_BACK: begin
									if (mode_r == MODE_TEST) begin
										devq_r <= '{1'b1, key_in.key == KEY_FWD ? DOP_FORCE_ON : DOP_FORCE_OFF,
											kind_r, dev_r}; // R6
										state_r <= ST_DEV;
									end else if (edit_mode && blocked) begin
										msg_r <= MSG_OP_BLOCKED; // R10
									end else if (edit_mode && entry_bad && !(mode_r == MODE_INSDEL
										&& key_in.key == KEY_BACK)) begin
										msg_r <= MSG_ENTRY; // R15
									end else if (edit_mode && (jump_low || jump_high) &&
										!(mode_r == MODE_INSDEL && key_in.key == KEY_BACK)) begin
										msg_r <= MSG_JUMP_TARGET; // R11
									end else if (mode_r == MODE_INSDEL) begin
										insert_r <= key_in.key == KEY_FWD; // R9
										ptr_r <= key_in.key == KEY_FWD ? program_end_in : step_r;
										mem_r <= '{1'b1, 1'b0, key_in.key == KEY_FWD ? program_end_in
											: ADDR_W'(step_r + 1'b1), '0};
										state_r <= ST_SH_RD;
									end else if (mode_r == MODE_WRITE && key_in.key == KEY_FWD) begin
										mem_r <= '{1'b1, 1'b1, step_r, entry_r};
										insert_r <= 1'b0;
										state_r <= ST_WR;
									end else begin
										step_r <= key_in.key == KEY_FWD ? ADDR_W'(step_r + 1'b1)
											: ADDR_W'(step_r - 1'b1); // R9
										mem_r <= '{1'b1, 1'b0, key_in.key == KEY_FWD ?
											ADDR_W'(step_r + 1'b1) : ADDR_W'(step_r - 1'b1), '0};
										state_r <= ST_RD;
									end
								end
								default: msg_r <= MSG_UNDEF_OP; // R18
							endcase
						end
					end
				end
				ST_RD: begin
					if (mem_ack_in) begin
						mem_r.req <= 1'b0;
						word_r <= mem_rdata_in;
						msg_r <= mem_rdata_in[15:12] == OP_BAD ? MSG_CODE : MSG_NONE; // R14
						state_r <= ST_IDLE;
					end
				end
				ST_SEARCH: begin
					if (mem_ack_in) begin
						if (mem_rdata_in == entry_r) begin
							mem_r.req <= 1'b0;
							step_r <= mem_r.addr;
							word_r <= mem_rdata_in;
							msg_r <= MSG_NONE; // R22
							state_r <= ST_IDLE;
						end else if (mem_r.addr >= program_end_in) begin
							mem_r.req <= 1'b0;
							msg_r <= MSG_NOT_FOUND; // R22
							state_r <= ST_IDLE;
						end else begin
							mem_r.addr <= ADDR_W'(mem_r.addr + 1'b1);
						end
					end
				end
				ST_SH_RD: begin
					if (mem_ack_in) begin
						mem_r <= '{1'b1, 1'b1, insert_r ? ADDR_W'(ptr_r + 1'b1) : ptr_r, mem_rdata_in};
						state_r <= ST_SH_WR;
					end
				end
				ST_SH_WR: begin
					if (mem_ack_in) begin
						if (insert_r && ptr_r != step_r) begin // R3
							ptr_r <= ADDR_W'(ptr_r - 1'b1);
							mem_r <= '{1'b1, 1'b0, ADDR_W'(ptr_r - 1'b1), '0};
							state_r <= ST_SH_RD;
						end else if (insert_r) begin
							mem_r <= '{1'b1, 1'b1, step_r, entry_r}; // R3
							state_r <= ST_WR;
						end else if (ptr_r != program_end_in) begin // R4
							ptr_r <= ADDR_W'(ptr_r + 1'b1);
							mem_r <= '{1'b1, 1'b0, ADDR_W'(ptr_r + 2'd2), '0};
							state_r <= ST_SH_RD;
						end else begin
							mem_r <= '{1'b1, 1'b1, program_end_in, WORD_NOP}; // R4
							entry_r <= WORD_NOP;
							state_r <= ST_WR;
						end
					end
				end
				ST_WR: begin
					if (mem_ack_in) begin
						word_r <= mem_r.data;
						mem_r.wr <= 1'b0; // R21
						state_r <= ST_VERIFY;
					end
				end
				ST_VERIFY: begin
					if (mem_ack_in) begin
						mem_r.req <= 1'b0;
						state_r <= ST_IDLE;
						if (mem_rdata_in != mem_r.data) begin
							msg_r <= MSG_WRITE_ERR; // R21
						end else if (push_over && entry_op == OP_JUMP) begin
							msg_r <= MSG_JUMP_TARGET; // R12
						end else if (entry_op == OP_OUT && coil_used_in) begin
							msg_r <= MSG_DUAL_COIL; // R13
						end else begin
							msg_r <= MSG_NONE;
						end
					end
				end
				ST_DEV: begin
					if (dev_ack_in) begin
						devq_r.req <= 1'b0;
						on_r <= dev_state_in; // R5
						show_r <= dev_value_in;
						show_dev_r <= kind_r inside {DEV_TIMER, DEV_COUNT, DEV_DATA};
						state_r <= ST_IDLE;
					end
				end
				default: state_r <= ST_OFF;
			endcase
		end
	end

	a_mode_sel: assert property (@(posedge clk_in) disable iff (srst_in) // R17
		key_go && mode_r == MODE_NONE && !mode_key &&
		!(key_in.key inside {KEY_CLEAR, KEY_PWR_OFF}) |=> msg_r == MSG_MODE_SEL)
		else $error("mode-selection error missing");
	a_blocked: assert property (@(posedge clk_in) disable iff (srst_in) // R10
		key_go && edit_mode && blocked && key_in.key inside {KEY_FWD, KEY_BACK}
		|=> msg_r == MSG_OP_BLOCKED && state_r == ST_IDLE)
		else $error("edit during run not refused");
	a_clear_ready: assert property (@(posedge clk_in) disable iff (srst_in) // R7
		key_go && key_in.key == KEY_CLEAR |=> msg_r == MSG_READY && entry_r == '0)
		else $error("clear did not return to ready");
	a_step_over: assert property (@(posedge clk_in) disable iff (srst_in) // R20
		key_go && mode_r != MODE_NONE && key_in.key == KEY_SET_STEP && step_over
		|=> msg_r == MSG_STEP_OVER && $stable(step_r))
		else $error("step overflow not flagged");
	a_verify: assert property (@(posedge clk_in) disable iff (srst_in) // R21
		state_r == ST_WR && mem_ack_in |=> state_r == ST_VERIFY && !mem_r.wr)
		else $error("write not read back");
	a_power: assert property (@(posedge clk_in) disable iff (srst_in) // R8
		key_go && key_in.key == KEY_PWR_OFF |=> !unit_power_out ##1 !unit_power_out)
		else $error("power off key ignored");
	a_hex: assert property (@(posedge clk_in) disable iff (srst_in) // R2
		hex_dev |-> display_out.dev_blank == 4'h0)
		else $error("hex device digits blanked");
	a_dec: assert property (@(posedge clk_in) disable iff (srst_in) // R2
		!hex_dev && dev_r < 12'h00A |-> display_out.dev_blank == 4'hE)
		else $error("decimal device leading zeros shown");
	a_ready_on: assert property (@(posedge clk_in) disable iff (srst_in) // R19
		state_r == ST_OFF && key_valid_in && key_in.key == KEY_PWR_ON |=> msg_r == MSG_READY)
		else $error("ready missing after power on");
endmodule : plc_program_editor_unit

// file: plc_program_editor_unit_tb.sv
`timescale 1ns/1ns
module plc_program_editor_unit_tb;
	import plc_editor_pkg::*;
	logic clk, srst, kv, run, rwe, ack, dack, dst, coil, pwr, busy, cor;
	key_evt_type key;
	logic [1:0] size;
	logic [3:0] dly;
	logic [11:0] mmax, pend, cerr;
	logic [15:0] rdata, dval;
	logic [15:0] snap [0:63];
	mem_req_type mreq;
	dev_req_type dreq;
	display_type disp;
	int miscompares, num_checks;
	plc_program_editor_unit i_plc_program_editor_unit (.clk_in(clk), .srst_in(srst),
		.key_valid_in(kv), .key_in(key), .cpu_size_sel_in(size), .mem_max_step_in(mmax),
		.cpu_running_in(run), .run_write_enable_in(rwe), .program_end_in(pend),
		.code_error_step_in(cerr), .mem_req_out(mreq), .mem_ack_in(ack), .mem_rdata_in(rdata),
		.dev_req_out(dreq), .dev_ack_in(dack), .dev_state_in(dst), .dev_value_in(dval),
		.coil_used_in(coil), .unit_power_out(pwr), .busy_out(busy), .display_out(disp));
	plc_mem_model i_plc_mem_model (.clk_in(clk), .mem_req_in(mreq), .mem_ack_out(ack),
		.mem_rdata_out(rdata), .dev_req_in(dreq), .dev_ack_out(dack), .dev_state_out(dst),
		.dev_value_out(dval), .delay_in(dly), .corrupt_in(cor));
	function automatic logic [15:0] m(input int a);
		return i_plc_mem_model.mem[a];
	endfunction : m
	task automatic chk(input string s, input logic [15:0] e, input logic [15:0] g);
		num_checks++;
		if (g !== e) begin
			miscompares++;
			$display("[ERR] %s expected %h seen %h", s, e, g);
		end
	endtask : chk
	task automatic chk_msg(input msg_type e);
		num_checks++;
		if (disp.msg !== e) begin
			miscompares++;
			$display("[ERR] msg expected %s seen %h", e.name(), disp.msg);
		end
	endtask : chk_msg
	// one key per idle cycle; keys during busy would be dropped, so wait it out
	task automatic press(input key_type k, input logic [15:0] v = 16'h0000);
		int n;
		n = 0;
		kv = 1'b1;
		key = '{k, v};
		@(negedge clk);
		kv = 1'b0;
		do begin
			@(negedge clk);
			n++;
		end while (busy !== 1'b0 && n < 3000);
		if (n >= 3000) begin
			miscompares++;
			$display("[ERR] busy expected 0 seen %b", busy);
		end
	endtask : press
	task automatic enter(input key_type md, input logic [11:0] s);
		press(KEY_CLEAR);
		press(md);
		press(KEY_SET_STEP, {4'h0, s});
	endtask : enter
	task automatic wr(input logic [11:0] s, input logic [15:0] w);
		enter(KEY_WRITE, s);
		press(KEY_INSTR, w);
		press(KEY_FWD);
	endtask : wr
	task automatic t_power;
		chk("power", 16'h0000, pwr);
		press(KEY_PWR_ON);
		chk("power", 16'h0001, pwr);
		chk_msg(MSG_READY);
		press(KEY_SET_STEP, 16'h0005);
		chk_msg(MSG_MODE_SEL);
		press(KEY_PWR_OFF);
		chk("power", 16'h0000, pwr);
		press(KEY_PWR_ON);
		chk_msg(MSG_READY);
		$display("t_power done");
	endtask : t_power
	task automatic t_read;
		enter(KEY_READ, 12'h000);
		press(KEY_SEARCH, 16'h1038);
		chk("step", 16'h0056, disp.step_digits);
		chk("blank", 16'h000C, disp.step_blank);
		chk("instr", 16'h1038, disp.instr);
		press(KEY_SEARCH, 16'h2222);
		chk_msg(MSG_NOT_FOUND);
		press(KEY_SEARCH, 16'h1038);
		chk_msg(MSG_NONE);
		press(KEY_SET_STEP, 16'h0003);
		chk("step", 16'h0003, disp.step_digits);
		enter(KEY_READ, 12'h01D);
		press(KEY_FWD);
		chk_msg(MSG_CODE);
		press(KEY_SET_STEP, 16'h0800);
		chk_msg(MSG_STEP_OVER);
		press(KEY_SET_STEP, 16'h07FF);
		chk_msg(MSG_NONE);
		press(KEY_BAD);
		chk_msg(MSG_UNDEF_OP);
		$display("t_read done");
	endtask : t_read
	task automatic t_write;
		logic [11:0] mx;
		wr(12'h005, 16'h1234);
		chk_msg(MSG_NONE);
		chk("word", 16'h1234, m(5));
		cor = 1'b1;
		wr(12'h006, 16'h1235);
		cor = 1'b0;
		chk_msg(MSG_WRITE_ERR);
		coil = 1'b1;
		wr(12'h007, 16'h3010);
		coil = 1'b0;
		chk_msg(MSG_DUAL_COIL);
		chk("word", 16'h3010, m(7));
		run = 1'b1;
		wr(12'h008, 16'h4444);
		chk_msg(MSG_OP_BLOCKED);
		chk("word", 16'h1008, m(8));
		rwe = 1'b1;
		wr(12'h009, 16'h4444);
		{run, rwe} = 2'b00;
		chk("word", 16'h4444, m(9));
		wr(12'h00A, 16'hA000);
		chk_msg(MSG_ENTRY);
		wr(12'h064, {OP_JUMP, 12'h032});
		chk_msg(MSG_JUMP_TARGET);
		for (int i = 0; i < 3; i++) begin
			size = i[1:0];
			mx = (i == 2) ? MAX_STEP_4K : i ? MAX_STEP_2K : MAX_STEP_1K;
			wr(12'h064, {OP_JUMP, mx + 12'h001});
			chk_msg(MSG_JUMP_TARGET);
			wr(12'h064, {OP_JUMP, mx});
			chk_msg(MSG_NONE);
		end
		size = 2'b00;
		enter(KEY_WRITE, 12'h00C);
		press(KEY_INSTR, 16'h5555);
		press(KEY_CLEAR);
		chk_msg(MSG_READY);
		chk("instr", 16'h0000, disp.instr);
		chk("word", 16'h100C, m(12));
		$display("t_write done");
	endtask : t_write
	task automatic t_insdel;
		dly = 4'h3;
		for (int i = 0; i < 64; i++) begin
			snap[i] = m(i);
		end
		enter(KEY_INSDEL, 12'h03A);
		press(KEY_INSTR, 16'h2345);
		press(KEY_FWD);
		chk("word", 16'h2345, m(58));
		for (int i = 58; i <= 60; i++) begin
			chk("shift", snap[i], m(i + 1));
		end
		pend = 12'h03D;
		enter(KEY_INSDEL, 12'h03A);
		press(KEY_BACK);
		for (int i = 58; i <= 60; i++) begin
			chk("shift", snap[i], m(i));
		end
		chk("word", WORD_NOP, m(61));
		run = 1'b1;
		enter(KEY_INSDEL, 12'h028);
		press(KEY_BACK);
		run = 1'b0;
		chk_msg(MSG_OP_BLOCKED);
		chk("word", snap[40], m(40));
		pend = MAX_STEP_1K;
		enter(KEY_INSDEL, 12'h3FE);
		press(KEY_INSTR, {OP_JUMP, 12'h3FE});
		press(KEY_FWD);
		chk_msg(MSG_JUMP_TARGET);
		chk("word", {OP_JUMP, 12'h3FE}, m(1022));
		pend = 12'h03C;
		dly = 4'h0;
		$display("t_insdel done");
	endtask : t_insdel
	task automatic t_devices;
		i_plc_mem_model.dev_st[16] = 1'b1;
		i_plc_mem_model.dev_val[2] = 16'd56;
		press(KEY_CLEAR);
		press(KEY_MONITOR);
		press(KEY_DEVICE, {DEV_OUT, 12'h010});
		chk("state", 16'h0001, disp.state_on);
		chk("dev", 16'h0010, disp.dev_digits);
		chk("devblank", 16'h0000, disp.dev_blank);
		press(KEY_DEVICE, {DEV_TIMER, 12'h002});
		chk("dev", 16'h0002, disp.dev_digits);
		chk("devblank", 16'h000E, disp.dev_blank);
		chk("step", 16'h0056, disp.step_digits);
		press(KEY_DEVICE, 16'h8001);
		chk_msg(MSG_DEV_SET);
		press(KEY_DEVICE, {DEV_OUT, 12'h100});
		chk_msg(MSG_DEV_OVER);
		press(KEY_CLEAR);
		press(KEY_TEST);
		press(KEY_DEVICE, {DEV_OUT, 12'h005});
		press(KEY_FWD);
		chk("forced", 16'h0001, i_plc_mem_model.dev_st[5]);
		press(KEY_BACK);
		chk("forced", 16'h0000, i_plc_mem_model.dev_st[5]);
		press(KEY_SET_STEP, 16'h8000);
		chk("step", 16'h0123, disp.step_digits);
		$display("t_devices done");
	endtask : t_devices
	task automatic wrap_up;
		$display("checks %0d miscompares %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : wrap_up
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	// far above the several hundred cycles the tests need
	initial begin
		#400000;
		miscompares++;
		$display("[ERR] run expected done seen hang");
		wrap_up;
	end
	initial begin
		{srst, kv, run, rwe, coil, cor} = 6'b100000;
		key = '0;
		size = 2'b00;
		dly = 4'h0;
		mmax = 12'h7FF;
		pend = 12'h03C;
		cerr = 12'h07B;
		repeat (16) @(negedge clk);
		for (int i = 0; i < 64; i++) begin
			i_plc_mem_model.mem[i] = 16'h1000 + 16'(i);
		end
		i_plc_mem_model.mem[30] = 16'hF000;
		srst = 1'b0;
		t_power;
		t_read;
		t_write;
		t_insdel;
		t_devices;
		wrap_up;
	end
endmodule : plc_program_editor_unit_tb
